/* File: irq_ctrl_regs.vh */
// Register indexes, field positions, reset values and timing counts of the interrupt block.
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH

// Register indexes; the byte address on the bus is four times the index.
`define REG_PRIMARY_IRQ_MASK 6'h14
`define REG_TIMER_FIELD_IRQ_MASK 6'h15
`define REG_ERROR_WAKE_IRQ_MASK 6'h16
`define REG_PRIMARY_IRQ_FLAGS 6'h17
`define REG_TIMER_FIELD_IRQ_FLAGS 6'h18
`define REG_ERROR_WAKE_IRQ_FLAGS 6'h19

// Reset values of masks and flags.
`define MASK_RESET 8'h00
`define FLAG_RESET 8'h00

// Primary register fields.
`define BIT_OSC_STABLE 7
`define BIT_FIFO_LEVEL 6
`define BIT_RX_START 5
`define BIT_RX_END 4
`define BIT_TX_END 3
`define BIT_BIT_COLLISION 2
`define BIT_TIMER_FIELD_PENDING 1
`define BIT_ERROR_WAKE_PENDING 0

// Timer and field register fields.
`define BIT_CMD_DONE 7
`define BIT_NO_RESP_EXPIRE 6
`define BIT_GP_TIMER_EXPIRE 5
`define BIT_FIELD_ON 4
`define BIT_FIELD_OFF 3
`define BIT_CA_COLLISION 2
`define BIT_GUARD_ELAPSED 1
`define BIT_BITRATE_FOUND 0

// Timing: clock period and the minimum guard time after switching the field on.
`define CLK_PERIOD_NS 10
`define GUARD_TIME_NS 5000
`define GUARD_CYCLES ((`GUARD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: irq_flag_bank.v */
// Bank of sticky interrupt flags with per-bit set, per-bit clear and a global clear.
`timescale 1ns/1ps
module irq_flag_bank #(
	parameter WIDTH = 8
) (
	// Clock and reset.
	input wire clk,
	input wire rst,
	// Control.
	input wire clear_all,
	input wire [WIDTH-1:0] set_bits,
	input wire [WIDTH-1:0] clr_bits,
	// State.
	output reg [WIDTH-1:0] flags_q
);

	genvar i;

	// Each flag is its own flip-flop; a set wins over a per-bit clear in the same cycle, but reset and the global clear win over a set.
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
			always @(posedge clk) begin
				if (rst || clear_all) begin
					flags_q[i] <= 1'b0;
				end else if (set_bits[i]) begin
					flags_q[i] <= 1'b1;
				end else if (clr_bits[i]) begin
					flags_q[i] <= 1'b0;
				end
			end
		end
	endgenerate

endmodule

/* File: irq_ctrl.v */
// Interrupt flag and mask block of the reader, with an Avalon-MM register slave.
//
// Contract
// [R1] Primary mask bits 7..2 block oscillator, FIFO, rx start/end, tx end, collision.
// [R2] Timer/field mask bits 7..0 block the eight timer and field sources.
// [R3] Error/wake mask bits 7..0 block the eight error and wake sources.
// [R4] All mask bits are zero after reset and after set-default.
// [R5] Primary flags bits 7..2 line up with the primary mask bits.
// [R6] Oscillator flag sets once the started oscillator reports stable.
// [R7] FIFO level flag sets in receive when FIFO nearly full; host drains.
// [R8] FIFO level flag sets in transmit when FIFO nearly empty; host refills.
// [R9] Primary bit 1 shows a pending timer/field flag.
// [R10] Primary bit 0 shows a pending error/wake flag.
// [R11] Reading primary clears bits 7..2; bits 1..0 clear on secondary read.
// [R12] Primary and timer/field flags read zero after reset and set-default.
// [R13] Timer/field flags hold the eight timer and field events, bit 7 down.
// [R14] Collision flag sets when an external field exists during collision avoidance.
// [R15] No external field: own field on, guard flag after minimum guard time.
// [R16] Reading the primary flags clears the timer/field flags.
// [R17] Error/wake flags sit at their own read-only address.
// [R18] Error/wake flags: CRC, parity, soft, hard framing, wake timer, amplitude, phase, capacitance.
// [R19] Request stays high while any unmasked flag is set; the code leaves the summary bits (primary bits 1..0) out of the request.
`timescale 1ns/1ps
`include "irq_ctrl_regs.vh"
module irq_ctrl #(
	parameter GUARD_CYCLES = `GUARD_CYCLES
) (
	// Clock and reset.
	input wire clk,
	input wire rst,
	// Avalon-MM register slave, byte addressed.
	input wire [7:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	output reg [31:0] readdata,
	output reg waitrequest,
	// Chip-level control.
	input wire set_default,
	// Oscillator and FIFO status levels.
	input wire osc_stable,
	input wire rx_mode,
	input wire tx_mode,
	input wire fifo_near_full,
	input wire fifo_near_empty,
	// Framing event pulses.
	input wire rx_start,
	input wire rx_end,
	input wire tx_end,
	input wire bit_collision,
	// Timer and target event pulses.
	input wire cmd_done,
	input wire no_resp_expire,
	input wire gp_timer_expire,
	input wire bitrate_found,
	// External field level and collision avoidance control.
	input wire ext_field,
	input wire ca_start,
	input wire field_off_cmd,
	// Error and wake-up event pulses, bit 7 = CRC down to bit 0 = capacitance.
	input wire [7:0] err_wake_events,
	// Outputs to the chip and the host.
	output reg field_on,
	output reg irq
);

	// Collision avoidance states.
	localparam CA_IDLE = 2'b00;
	localparam CA_GUARD = 2'b01;
	localparam CA_DONE = 2'b10;

	localparam [31:0] GUARD_LAST = GUARD_CYCLES - 1;

	// Mask registers.
	reg [7:0] mask_primary_q;
	reg [7:0] mask_timer_q;
	reg [7:0] mask_error_q;

	// Bus sequencing and snapshots of what a read returned.
	wire [5:0] reg_index;
	wire req_first;
	wire req_accept;
	wire wr_accept;
	wire rd_accept;
	reg [7:0] rd_value_d;
	reg [5:0] snap_primary_q;
	reg [7:0] snap_timer_q;
	reg [7:0] snap_error_q;
	wire rd_primary;
	wire rd_timer;
	wire rd_error;

	// Event detection.
	reg osc_prev_q;
	reg fifo_cond_prev_q;
	reg ext_field_prev_q;
	wire fifo_cond;
	wire [5:0] primary_set;
	wire [7:0] timer_set;
	wire [1:0] summary_set;
	wire [1:0] summary_clr;

	// Flag banks.
	wire [5:0] primary_flags;
	wire [7:0] timer_flags;
	wire [7:0] error_flags;
	wire [1:0] summary_flags;
	wire [7:0] primary_view;

	// Collision avoidance sequencer.
	reg [1:0] ca_state_q;
	reg [1:0] ca_state_d;
	reg [31:0] guard_cnt_q;
	reg ca_collision;
	reg guard_elapsed;

	// A request is seen first with waitrequest high; the next cycle drops it and completes.
	assign reg_index = address[7:2];
	assign req_first = (read || write) && waitrequest;
	assign req_accept = (read || write) && !waitrequest;
	assign wr_accept = req_accept && write && byteenable[0];
	assign rd_accept = req_accept && read;
	assign rd_primary = rd_accept && (reg_index == `REG_PRIMARY_IRQ_FLAGS);
	assign rd_timer = rd_accept && (reg_index == `REG_TIMER_FIELD_IRQ_FLAGS);
	assign rd_error = rd_accept && (reg_index == `REG_ERROR_WAKE_IRQ_FLAGS);

	// Waitrequest holds high at idle and falls for exactly one cycle per request.
	always @(posedge clk) begin
		if (rst) begin
			waitrequest <= 1'b1;
		end else if (req_first) begin
			waitrequest <= 1'b0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// Primary view: event flags on top, sticky summary bits below.
	assign primary_view = {primary_flags, summary_flags}; // see [R5]

	// Read mux; unmapped indexes and unused mask bits read as zero.
	always @* begin
		case (reg_index)
			`REG_PRIMARY_IRQ_MASK: rd_value_d = {mask_primary_q[7:2], 2'b00};
			`REG_TIMER_FIELD_IRQ_MASK: rd_value_d = mask_timer_q;
			`REG_ERROR_WAKE_IRQ_MASK: rd_value_d = mask_error_q;
			`REG_PRIMARY_IRQ_FLAGS: rd_value_d = primary_view;
			`REG_TIMER_FIELD_IRQ_FLAGS: rd_value_d = timer_flags; // see [R13]
			`REG_ERROR_WAKE_IRQ_FLAGS: rd_value_d = error_flags; // see [R17]
			default: rd_value_d = 8'h00;
		endcase
	end

	// Read data is latched in the first cycle so it stands at the completing edge.
	// The same snapshot decides which primary, timer and error flags the read clears, so one
	// of those that rises between the snapshot and the completion is not wiped unseen.
	always @(posedge clk) begin
		if (rst) begin
			readdata <= 32'h0000_0000;
			snap_primary_q <= 6'h00;
			snap_timer_q <= 8'h00;
			snap_error_q <= 8'h00;
		end else if (req_first) begin
			readdata <= {24'h00_0000, read ? rd_value_d : 8'h00};
			snap_primary_q <= primary_flags;
			snap_timer_q <= timer_flags;
			snap_error_q <= error_flags;
		end
	end

	// Mask registers; the unused low bits of the primary mask stay zero.
	always @(posedge clk) begin
		if (rst || set_default) begin
			mask_primary_q <= `MASK_RESET; // see [R4]
			mask_timer_q <= `MASK_RESET; // see [R4]
			mask_error_q <= `MASK_RESET; // see [R4]
		end else if (wr_accept) begin
			case (reg_index)
				`REG_PRIMARY_IRQ_MASK: mask_primary_q <= {writedata[7:2], 2'b00}; // see [R1]
				`REG_TIMER_FIELD_IRQ_MASK: mask_timer_q <= writedata[7:0]; // see [R2]
				`REG_ERROR_WAKE_IRQ_MASK: mask_error_q <= writedata[7:0]; // see [R3]
				default: mask_primary_q <= mask_primary_q;
			endcase
		end
	end

	// Previous values for edge detection of status levels.
	always @(posedge clk) begin
		if (rst) begin
			osc_prev_q <= 1'b0;
			fifo_cond_prev_q <= 1'b0;
			ext_field_prev_q <= 1'b0;
		end else begin
			osc_prev_q <= osc_stable;
			fifo_cond_prev_q <= fifo_cond;
			ext_field_prev_q <= ext_field;
		end
	end

	// The FIFO level condition depends on direction: nearly full while receiving,
	// nearly empty while sending. Only its rising edge raises the flag, so a host
	// that is slow to service the FIFO gets one request, not a stream of them.
	assign fifo_cond = (rx_mode && fifo_near_full) || (tx_mode && fifo_near_empty); // see [R7] [R8]

	// Primary event sources, bit 7 down to bit 2.
	assign primary_set = {
		osc_stable && !osc_prev_q, // see [R6]
		fifo_cond && !fifo_cond_prev_q,
		rx_start,
		rx_end,
		tx_end,
		bit_collision
	};

	// Timer and field event sources, bit 7 down to bit 0.
	assign timer_set = {
		cmd_done,
		no_resp_expire,
		gp_timer_expire,
		ext_field && !ext_field_prev_q,
		!ext_field && ext_field_prev_q,
		ca_collision, // see [R14]
		guard_elapsed, // see [R15]
		bitrate_found
	};

	// Primary flags clear on a primary read; only bits that were actually returned clear.
	irq_flag_bank #(
		.WIDTH(6)
	) u_primary (
		.clk(clk),
		.rst(rst),
		.clear_all(set_default), // see [R12]
		.set_bits(primary_set),
		.clr_bits(rd_primary ? snap_primary_q : 6'h00), // see [R11]
		.flags_q(primary_flags)
	);

	// Timer and field flags clear on a primary read as well as on their own read.
	irq_flag_bank #(
		.WIDTH(8)
	) u_timer (
		.clk(clk),
		.rst(rst),
		.clear_all(set_default), // see [R12]
		.set_bits(timer_set),
		.clr_bits((rd_primary || rd_timer) ? snap_timer_q : 8'h00), // see [R16]
		.flags_q(timer_flags)
	);

	// Error and wake-up flags behave like the timer and field flags.
	irq_flag_bank #(
		.WIDTH(8)
	) u_error (
		.clk(clk),
		.rst(rst),
		.clear_all(set_default),
		.set_bits(err_wake_events), // see [R18]
		.clr_bits((rd_primary || rd_error) ? snap_error_q : 8'h00),
		.flags_q(error_flags)
	);

	// Summary bits are sticky: they survive the primary read that empties the
	// secondary registers, so the host still learns which register to inspect.
	assign summary_set = {|timer_set, |err_wake_events}; // see [R9] [R10]
	assign summary_clr = {rd_timer, rd_error}; // see [R11]

	irq_flag_bank #(
		.WIDTH(2)
	) u_summary (
		.clk(clk),
		.rst(rst),
		.clear_all(set_default),
		.set_bits(summary_set),
		.clr_bits(summary_clr),
		.flags_q(summary_flags)
	);

	// Collision avoidance next state.
	always @* begin
		ca_state_d = ca_state_q;
		ca_collision = 1'b0;
		guard_elapsed = 1'b0;
		case (ca_state_q)
			CA_IDLE: begin
				if (ca_start && ext_field) begin
					ca_collision = 1'b1; // see [R14]
				end else if (ca_start) begin
					ca_state_d = CA_GUARD;
				end
			end
			CA_GUARD: begin
				if (guard_cnt_q == GUARD_LAST) begin
					guard_elapsed = 1'b1; // see [R15]
					ca_state_d = CA_DONE;
				end
			end
			CA_DONE: begin
				ca_state_d = CA_IDLE;
			end
			default: begin
				ca_state_d = CA_IDLE;
			end
		endcase
	end

	// Sequencer state, guard counter and own field enable. The field stays on
	// after the guard time; only an explicit off command, set-default or reset drops it.
	always @(posedge clk) begin
		if (rst || set_default) begin
			ca_state_q <= CA_IDLE;
			guard_cnt_q <= 32'h0000_0000;
			field_on <= 1'b0;
		end else begin
			ca_state_q <= ca_state_d;
			if (ca_state_q == CA_IDLE && ca_start && !ext_field) begin
				field_on <= 1'b1; // see [R15]
				guard_cnt_q <= 32'h0000_0000;
			end else if (ca_state_q == CA_GUARD) begin
				guard_cnt_q <= guard_cnt_q + 32'h0000_0001;
			end else if (field_off_cmd) begin
				field_on <= 1'b0;
			end
		end
	end

	// Request line: registered OR of every unmasked flag, excluding the summary bits.
	// The summary bits are gated by no mask of their own; a masked secondary flag
	// still shows in them, so they are left out of the request to honour that mask.
	always @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(primary_flags & ~mask_primary_q[7:2]) // see [R1] [R19]
				| |(timer_flags & ~mask_timer_q) // see [R2]
				| |(error_flags & ~mask_error_q); // see [R3]
		end
	end

endmodule

/* File: irq_chk.sv */
// Port-level assertions for the interrupt flag and mask block.
`timescale 1ns/1ps
module irq_chk #(
	parameter GUARD_CYCLES = 4
) (
	// Clock and reset.
	input wire clk,
	input wire rst,
	// Register bus.
	input wire [7:0] address,
	input wire read,
	input wire write,
	input wire [31:0] readdata,
	input wire waitrequest,
	// Control inputs.
	input wire set_default,
	input wire ca_start,
	input wire ext_field,
	// Outputs.
	input wire field_on,
	input wire irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Anything that may lower the request legally; it takes two edges to reach irq.
	wire chg = write | set_default | (read & ~waitrequest);

	wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered after one wait cycle");
	wait_once_a: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	pad_zero_a: assert property (read && !waitrequest && address[7:2] == 6'h14 |-> readdata[1:0] == 2'h0)
		else $error("unused primary mask bits read nonzero");
	upper_zero_a: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
		else $error("read data above the register byte not zero");
	irq_hold_a: assert property (irq && !chg && !$past(chg) |=> irq)
		else $error("request dropped without a clear or mask change");
	rst_idle_a: assert property ($fell(rst) |-> !irq && !field_on && waitrequest)
		else $error("outputs not idle after reset");
	field_cause_a: assert property ($rose(field_on) |-> $past(ca_start && !ext_field))
		else $error("own field switched on without a clear start");
	field_blocked_a: assert property (ca_start && ext_field && !field_on |=> !field_on)
		else $error("own field switched on over an outside field");
	guard_hold_a: assert property (disable iff (rst || set_default) $rose(field_on) |-> field_on[*4])
		else $error("own field dropped during guard time");
endmodule

bind irq_ctrl irq_chk #(.GUARD_CYCLES(GUARD_CYCLES)) chk (.clk, .rst, .address, .read, .write,
	.readdata, .waitrequest, .set_default, .ca_start, .ext_field, .field_on, .irq);

/* File: host_bus.sv */
// Host microcontroller model: Avalon-MM master for the interrupt registers.
`timescale 1ns/1ps
module host_bus (
	// Clock.
	input wire clk,
	// Avalon-MM master side.
	output reg [7:0] address,
	output reg read,
	output reg write,
	output reg [31:0] writedata,
	output reg [3:0] byteenable,
	input wire [31:0] readdata,
	input wire waitrequest
);
	// Idle bus at time zero.
	initial begin
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		byteenable = 4'hf;
	end

	// One write; an edge passes first so back-to-back calls never re-drive in one step.
	task wr(input [7:0] a, input [7:0] d, input [3:0] be);
		begin
			@(posedge clk);
			address <= a;
			writedata <= {24'h0, d};
			byteenable <= be;
			write <= 1'b1;
			@(posedge clk);
			while (waitrequest) @(posedge clk);
			write <= 1'b0;
		end
	endtask

	// One read; data are taken at the edge that sees waitrequest low.
	task rd(input [7:0] a, output [7:0] d);
		begin
			@(posedge clk);
			address <= a;
			read <= 1'b1;
			@(posedge clk);
			while (waitrequest) @(posedge clk);
			d = readdata[7:0];
			read <= 1'b0;
		end
	endtask
endmodule

/* File: test_irq_ctrl.sv */
// Self-checking testbench of the interrupt flag and mask block.
`timescale 1ns/1ps
module test_irq_ctrl;
	localparam GC = 4;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg [18:0] ev = 19'h0;
	reg osc_stable = 1'b0;
	reg rx_mode = 1'b0;
	reg tx_mode = 1'b0;
	reg fifo_near_full = 1'b0;
	reg fifo_near_empty = 1'b0;
	reg ext_field = 1'b0;
	reg [23:0] efl = {8'hff, 8'he1, 8'h3c};
	reg [7:0] d;
	wire [7:0] address;
	wire [31:0] writedata, readdata;
	wire [3:0] byteenable;
	wire read, write, waitrequest, field_on, irq;
	integer errors = 0;
	integer n_checks = 0;
	integer r, b, i;

	// Free-running 100 MHz clock.
	always #5 clk = ~clk;

	host_bus host (.clk(clk), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest));

	irq_ctrl #(.GUARD_CYCLES(GC)) dut (.clk(clk), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .set_default(ev[18]), .osc_stable(osc_stable),
		.rx_mode(rx_mode), .tx_mode(tx_mode), .fifo_near_full(fifo_near_full),
		.fifo_near_empty(fifo_near_empty), .rx_start(ev[15]), .rx_end(ev[14]),
		.tx_end(ev[13]), .bit_collision(ev[12]), .cmd_done(ev[11]), .no_resp_expire(ev[10]),
		.gp_timer_expire(ev[9]), .bitrate_found(ev[8]), .ext_field(ext_field),
		.ca_start(ev[17]), .field_off_cmd(ev[16]), .err_wake_events(ev[7:0]),
		.field_on(field_on), .irq(irq));

	task chk(input [7:0] got, input [7:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("mismatch at %0t: got %h, expected %h", $time, got, exp);
			end
		end
	endtask

	task rdc(input [7:0] a, input [7:0] exp);
		begin
			host.rd(a, d);
			chk(d, exp);
		end
	endtask

	// Event strobes last exactly one cycle.
	task pulse(input [18:0] v);
		begin
			@(posedge clk);
			ev <= v;
			@(posedge clk);
			ev <= 19'h0;
		end
	endtask

	// All six registers and one unmapped place read zero.
	task all_zero;
		for (i = 0; i < 7; i = i + 1) rdc(8'(8'h50 + 4 * i), 8'h00);
	endtask

	task give_verdict;
		begin
			if (errors == 0 && n_checks > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask

	// Watchdog sized well above the fewer than a thousand cycles the sequence needs.
	initial begin
		repeat (20000) @(posedge clk);
		errors = errors + 1;
		give_verdict;
	end

	// Main sequence.
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		all_zero;
		for (i = 0; i < 3; i = i + 1) host.wr(8'(8'h50 + 4 * i), 8'hff, 4'hf);
		rdc(8'h50, 8'hfc);
		rdc(8'h54, 8'hff);
		host.wr(8'h58, 8'h00, 4'h0);
		rdc(8'h58, 8'hff);
		// A write to a flag register must leave it empty.
		host.wr(8'h5c, 8'hff, 4'hf);
		rdc(8'h5c, 8'h00);
		// Everything masked: flags gather while the request stays low.
		osc_stable <= 1'b1;
		rx_mode <= 1'b1;
		fifo_near_full <= 1'b1;
		pulse(19'h0ffff);
		repeat (3) @(posedge clk);
		chk({7'h0, irq}, 8'h00);
		rdc(8'h5c, 8'hff);
		rdc(8'h5c, 8'h03);
		rdc(8'h60, 8'h00);
		rdc(8'h64, 8'h00);
		rdc(8'h5c, 8'h00);
		// Transmit side: the FIFO running low raises the level flag again.
		// The receive condition drops for one edge first; a direct swap would keep
		// the combined level high and never show the rising edge the flag needs.
		rx_mode <= 1'b0;
		@(posedge clk);
		tx_mode <= 1'b1;
		fifo_near_empty <= 1'b1;
		repeat (3) @(posedge clk);
		rdc(8'h5c, 8'h40);
		// Collision avoidance first against an outside field, then into a quiet band.
		ext_field <= 1'b1;
		pulse(19'h20000);
		repeat (2) @(posedge clk);
		chk({7'h0, field_on}, 8'h00);
		ext_field <= 1'b0;
		pulse(19'h20000);
		pulse(19'h10000);
		repeat (GC + 2) @(posedge clk);
		chk({7'h0, field_on}, 8'h01);
		rdc(8'h60, 8'h1e);
		// Once the guard time is over the off command drops the own field.
		pulse(19'h10000);
		@(posedge clk);
		chk({7'h0, field_on}, 8'h00);
		// One source unmasked at a time; summary bits must not raise the request.
		for (r = 0; r < 3; r = r + 1) begin
			for (b = 0; b < 8; b = b + 1) begin
				for (i = 0; i < 3; i = i + 1)
					host.wr(8'(8'h50 + 4 * i), (i == r) ? ~(8'h01 << b) : 8'hff, 4'hf);
				pulse(19'h0ffff);
				repeat (3) @(posedge clk);
				chk({7'h0, irq}, {7'h0, efl[8 * r + b]});
				rdc(8'h60, 8'he1);
				rdc(8'h64, 8'hff);
				rdc(8'h5c, 8'h3c);
				repeat (3) @(posedge clk);
				chk({7'h0, irq}, 8'h00);
			end
		end
		// Set-default with sources pending wipes masks and flags.
		pulse(19'h0ffff);
		pulse(19'h40000);
		repeat (3) @(posedge clk);
		chk({7'h0, irq}, 8'h00);
		all_zero;
		give_verdict;
	end
endmodule
